// File: design/mtic_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "mtic_regs.svh"
module mtic_top #(
    parameter int unsigned STALE_CYC = `MTIC_STALE_CYC
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // APB slave
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        irq,
    // Receive pin and auxiliary pin
    input  wire logic                   rx_pin,
    output logic                        aux_out,
    output logic                        aux_oe_n,
    // Converter
    output logic                        adc_start,
    input  wire mtic_pkg::mtic_adc_rsp_t adc_rsp,
    // Serial command front end
    input  wire mtic_pkg::mtic_ser_cmd_t ser_cmd,
    output logic [15:0]                 baud_div,
    output logic                        crc_en,
    // Target to the loop
    output mtic_pkg::mtic_tgt_t         target
);
    mtic_pkg::mtic_st_t s;
    mtic_pkg::mtic_st_t next_s;
    logic               pw_upd;
    logic [11:0]        pw_width;
    logic [11:0]        raw_pw;

    assign prdata    = s.prdata;
    assign pready    = s.pready;
    assign pslverr   = s.pslverr;
    assign irq       = s.irq;
    assign aux_out   = s.aux_out;
    assign aux_oe_n  = s.aux_oe_n;
    assign adc_start = s.adc_start;
    assign baud_div  = s.serw[`MTIC_SER_BAUD];
    assign crc_en    = s.ctrl[`MTIC_CTRL_CRC];
    assign target    = s.tgt;

    mtic_pulse u_pulse (
        .core_clk (core_clk),
        .resetn   (resetn),
        .tick     (s.tick15),
        .rx       (s.rx2),
        .upd      (pw_upd),
        .width    (pw_width)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Straight-line interpolation; a flat or reversed span yields the start point
    function automatic logic [11:0] mtic_lerp(input logic [11:0] x,
                                              input logic [11:0] x0,
                                              input logic [11:0] x1,
                                              input logic [11:0] y0,
                                              input logic [11:0] y1);
        logic signed [13:0] dx;
        logic signed [13:0] dy;
        logic signed [13:0] sp;
        logic signed [27:0] q;
        begin
            dx = $signed({2'b00, x}) - $signed({2'b00, x0});
            dy = $signed({2'b00, y1}) - $signed({2'b00, y0});
            sp = $signed({2'b00, x1}) - $signed({2'b00, x0});
            if (sp <= 14'sd0) begin
                mtic_lerp = y0;
            end else begin
                q = (dx * dy) / sp;
                q = q + $signed({16'h0000, y0});
                mtic_lerp = q[11:0];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic              acc_ph;
    logic              wr;
    logic [3:0]        clr;
    logic [3:0]        set;
    logic              loop_tick;
    logic              ser_ok;
    logic [11:0]       r;
    logic [11:0]       t_lo;
    logic [11:0]       t_hi;
    logic [11:0]       t_map;
    logic [19:0]       sum;
    logic [7:0]        need;
    logic [2:0]        lg;
    mtic_pkg::mtic_mode_t mode;

    // Pulse result is held here so a mode change keeps the last good width
    logic [11:0] pw_hold;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pw_hold <= 12'h000;
        end else if (pw_upd) begin
            pw_hold <= pw_width;
        end
    end
    assign raw_pw = pw_hold;

    always_comb begin
        next_s    = s;
        mode      = mtic_pkg::mtic_mode_t'(s.ctrl[`MTIC_CTRL_MODE]);
        lg        = s.loopw[`MTIC_LOOP_SMP];
        need      = 8'h01 << lg;
        set       = 4'h0;
        clr       = 4'h0;
        acc_ph    = 1'b0;
        sum       = 20'h0_0000;
        r         = 12'h000;
        t_lo      = 12'h000;
        t_hi      = 12'h000;
        t_map     = 12'h000;
        ser_ok    = 1'b0;
        loop_tick = 1'b0;

        // Pin synchroniser, then a 3/200 phase step for an exact 1.5 MHz mean rate
        next_s.rx1    = rx_pin;
        next_s.rx2    = s.rx1;
        next_s.tick15 = 1'b0;
        if (s.phase >= 8'(`MTIC_TICK_DEN - `MTIC_TICK_NUM)) begin
            next_s.phase  = s.phase - 8'(`MTIC_TICK_DEN - `MTIC_TICK_NUM);
            next_s.tick15 = 1'b1;
        end else begin
            next_s.phase = s.phase + 8'(`MTIC_TICK_NUM);
        end

        // APB: one wait state, registered answer
        wr             = psel && penable && s.pready && pwrite;
        next_s.pready  = psel && penable && !s.pready;
        next_s.pslverr = 1'b0;
        if (psel && penable && !s.pready && !pwrite) begin
            next_s.prdata = 32'h0000_0000;
            case (paddr)
                `MTIC_OFF_CTRL:   next_s.prdata = s.ctrl;
                `MTIC_OFF_STATUS: next_s.prdata = {28'h000_0000, s.status};
                `MTIC_OFF_MASK:   next_s.prdata = {28'h000_0000, s.mask};
                `MTIC_OFF_ABS:    next_s.prdata = s.absw;
                `MTIC_OFF_SPAN:   next_s.prdata = s.spanw;
                `MTIC_OFF_NEU:    next_s.prdata = s.neuw;
                `MTIC_OFF_TGT:    next_s.prdata = s.tgtw;
                `MTIC_OFF_TNEU:   next_s.prdata = s.tneuw;
                `MTIC_OFF_LOOP:   next_s.prdata = s.loopw;
                `MTIC_OFF_SER:    next_s.prdata = s.serw;
                `MTIC_OFF_CMD:    next_s.prdata = {20'h0_0000, s.cmd_tgt};
                `MTIC_OFF_STATE:  next_s.prdata = {s.an_busy, 3'h0, s.tgt.target,
                                                   4'h0, s.raw};
                default:          next_s.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            case (paddr)
                `MTIC_OFF_CTRL:   next_s.ctrl  = pwdata & `MTIC_WM_CTRL;
                `MTIC_OFF_STATUS: clr          = pwdata[3:0];
                `MTIC_OFF_MASK:   next_s.mask  = pwdata[3:0];
                `MTIC_OFF_ABS:    next_s.absw  = pwdata & `MTIC_WM_PAIR;
                `MTIC_OFF_SPAN:   next_s.spanw = pwdata & `MTIC_WM_PAIR;
                `MTIC_OFF_NEU:    next_s.neuw  = pwdata & `MTIC_WM_PAIR;
                `MTIC_OFF_TGT:    next_s.tgtw  = pwdata & `MTIC_WM_PAIR;
                `MTIC_OFF_TNEU:   next_s.tneuw = pwdata & `MTIC_WM_TNEU;
                `MTIC_OFF_LOOP:   next_s.loopw = pwdata & `MTIC_WM_LOOP;
                `MTIC_OFF_SER:    next_s.serw  = pwdata;
                `MTIC_OFF_CMD:    next_s.cmd_tgt = pwdata[11:0];
                default:          next_s.cmd_tgt = s.cmd_tgt;
            endcase
        end

        // Serial target from either port; with CRC on, a bad check drops the command
        if (ser_cmd.valid && (ser_cmd.crc_ok || !s.ctrl[`MTIC_CTRL_CRC])) begin
            ser_ok         = 1'b1;
            next_s.cmd_tgt = ser_cmd.target;
        end

        // Loop period divider
        if (s.loop_cnt + 20'h0_0001 >= s.loopw[`MTIC_LOOP_PER]) begin
            next_s.loop_cnt = 20'h0_0000;
            loop_tick       = 1'b1;
        end else begin
            next_s.loop_cnt = s.loop_cnt + 20'h0_0001;
        end

        // Analog batch: one converter request at a time
        next_s.adc_start = 1'b0;
        if (s.an_busy && adc_rsp.done) begin
            sum           = s.an_sum + {8'h00, adc_rsp.code, 2'b00};
            next_s.an_sum = sum;
            next_s.an_cnt = s.an_cnt + 8'h01;
            if (s.an_cnt + 8'h01 >= need) begin
                next_s.an_busy  = 1'b0;
                next_s.aux_out  = 1'b1;
                if (s.disc_now) begin
                    if ((sum >> lg) != 20'h0_0000)
                        set[`MTIC_ST_RANGE] = 1'b1;
                end else begin
                    next_s.raw_an = 12'(sum >> lg);
                end
                next_s.disc_now = 1'b0;
            end else begin
                next_s.adc_start = 1'b1;
            end
        end
        next_s.aux_oe_n = !s.ctrl[`MTIC_CTRL_DISC];

        if (loop_tick) begin
            if (mode == mtic_pkg::MODE_ANALOG) begin
                // Late batch is dropped and restarted so the input stays periodic
                if (s.an_busy)
                    set[`MTIC_ST_OVR] = 1'b1;
                next_s.an_busy   = 1'b1;
                next_s.an_cnt    = 8'h00;
                next_s.an_sum    = 20'h0_0000;
                next_s.adc_start = 1'b1;
                next_s.disc_cnt  = s.disc_cnt + 4'h1;
                if (s.ctrl[`MTIC_CTRL_DISC] && s.disc_cnt == 4'(`MTIC_DISC_EVERY - 1)) begin
                    next_s.disc_now = 1'b1;
                    next_s.aux_out  = 1'b0;
                end else begin
                    next_s.disc_now = 1'b0;
                    next_s.aux_out  = 1'b1;
                end
            end else begin
                next_s.an_busy  = 1'b0;
                next_s.disc_now = 1'b0;
                next_s.aux_out  = 1'b1;
            end

            // Pick the one active source
            case (mode)
                mtic_pkg::MODE_ANALOG: r = s.raw_an;
                mtic_pkg::MODE_PULSE:  r = raw_pw;
                default:               r = s.cmd_tgt;
            endcase
            next_s.raw = r;

            // Invert swaps which endpoint each side of neutral reaches
            t_lo = s.ctrl[`MTIC_CTRL_INV] ? s.tgtw[`MTIC_HI] : s.tgtw[`MTIC_LO];
            t_hi = s.ctrl[`MTIC_CTRL_INV] ? s.tgtw[`MTIC_LO] : s.tgtw[`MTIC_HI];
            if (r <= s.spanw[`MTIC_LO])
                t_map = t_lo;
            else if (r >= s.spanw[`MTIC_HI])
                t_map = t_hi;
            else if (r >= s.neuw[`MTIC_LO] && r <= s.neuw[`MTIC_HI])
                t_map = s.tneuw[`MTIC_LO];
            else if (r < s.neuw[`MTIC_LO])
                t_map = mtic_lerp(r, s.spanw[`MTIC_LO], s.neuw[`MTIC_LO],
                                  t_lo, s.tneuw[`MTIC_LO]);
            else
                t_map = mtic_lerp(r, s.neuw[`MTIC_HI], s.spanw[`MTIC_HI],
                                  s.tneuw[`MTIC_LO], t_hi);

            // Serial commands set the target directly, unscaled
            if (mode == mtic_pkg::MODE_SERIAL || mode == mtic_pkg::MODE_SPARE) begin
                next_s.tgt.target = s.cmd_tgt;
            end else begin
                next_s.tgt.target = t_map;
                if (r < s.absw[`MTIC_LO] || r > s.absw[`MTIC_HI])
                    set[`MTIC_ST_RANGE] = 1'b1;
            end

            // Silence measured in loop periods
            if (ser_ok)
                next_s.ser_idle = 16'h0000;
            else if (s.ser_idle != 16'hFFFF)
                next_s.ser_idle = s.ser_idle + 16'h0001;
            if (mode == mtic_pkg::MODE_SERIAL && s.serw[`MTIC_SER_TMO] != 16'h0000
                && s.ser_idle >= s.serw[`MTIC_SER_TMO])
                set[`MTIC_ST_SILENT] = 1'b1;
        end else if (ser_ok) begin
            next_s.ser_idle = 16'h0000;
        end
        // Never leave the pin pulled low once the check is switched off
        if (!s.ctrl[`MTIC_CTRL_DISC])
            next_s.aux_out = 1'b1;
        next_s.tgt.valid = loop_tick;

        // Stale pulse watch
        if (pw_upd || mode != mtic_pkg::MODE_PULSE)
            next_s.stale_cnt = 24'h00_0000;
        else if (s.stale_cnt != 24'hFF_FFFF)
            next_s.stale_cnt = s.stale_cnt + 24'h00_0001;
        if (mode == mtic_pkg::MODE_PULSE && s.stale_cnt > 24'(STALE_CYC))
            set[`MTIC_ST_STALE] = 1'b1;

        // Sticky flags: a new event beats a clear in the same cycle
        next_s.status = (s.status & ~clr) | set;
        next_s.irq    = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s          <= '0;
            s.ctrl     <= `MTIC_RST_CTRL;
            s.absw     <= `MTIC_RST_ABS;
            s.spanw    <= `MTIC_RST_SPAN;
            s.neuw     <= `MTIC_RST_NEU;
            s.tgtw     <= `MTIC_RST_TGT;
            s.tneuw    <= `MTIC_RST_TNEU;
            s.loopw    <= `MTIC_RST_LOOP;
            s.serw     <= `MTIC_RST_SER;
            s.aux_out  <= 1'b1;
            s.aux_oe_n <= 1'b1;
            s.cmd_tgt  <= 12'h800;
        end else begin
            s <= next_s;
        end
    end
endmodule

// File: include/mtic_regs.svh
`ifndef MTIC_REGS_SVH
`define MTIC_REGS_SVH
// Notes on behaviour
// - Target comes from one selected input mode
// - Serial targets accepted from USB or TTL
// - Analog 0 V to 5 V gives 0 to 4092
// - Pulse input counted in two-thirds microsecond ticks
// - Pulses 400-2600 us at 10-150 Hz
// - Update only after four valid pulses running
// - Stale pulse error after 120 ms silence
// - Input min/max map to target endpoints
// - Neutral band maps to neutral target
// - Range fault outside absolute low/high window
// - Invert swaps directions before scaling
// - Analog averages configurable samples per period
// - Overrun flagged when sampling outlasts period
// - Disconnect check drives aux low, expects 0
// - Fixed baud rate and optional command CRC; baud_div is writable in SER bits 31:16
// - Serial silence error; zero timeout disables
// - Processing runs once per loop period

// Register byte offsets
`define MTIC_OFF_CTRL   8'h00
`define MTIC_OFF_STATUS 8'h04
`define MTIC_OFF_MASK   8'h08
`define MTIC_OFF_ABS    8'h0C
`define MTIC_OFF_SPAN   8'h10
`define MTIC_OFF_NEU    8'h14
`define MTIC_OFF_TGT    8'h18
`define MTIC_OFF_TNEU   8'h1C
`define MTIC_OFF_LOOP   8'h20
`define MTIC_OFF_SER    8'h24
`define MTIC_OFF_CMD    8'h28
`define MTIC_OFF_STATE  8'h2C

// Field positions
`define MTIC_CTRL_MODE  1:0
`define MTIC_CTRL_INV   2
`define MTIC_CTRL_CRC   3
`define MTIC_CTRL_DISC  4
`define MTIC_LO         11:0
`define MTIC_HI         27:16
`define MTIC_LOOP_PER   19:0
`define MTIC_LOOP_SMP   26:24
`define MTIC_SER_TMO    15:0
`define MTIC_SER_BAUD   31:16
`define MTIC_ST_RANGE   0
`define MTIC_ST_STALE   1
`define MTIC_ST_SILENT  2
`define MTIC_ST_OVR     3

// Reset values and writable bits
`define MTIC_RST_CTRL   32'h0000_0000
`define MTIC_RST_ABS    32'h0FFF_0000
`define MTIC_RST_SPAN   32'h0FFF_0000
`define MTIC_RST_NEU    32'h0800_0800
`define MTIC_RST_TGT    32'h0FFF_0000
`define MTIC_RST_TNEU   32'h0000_0800
`define MTIC_RST_LOOP   32'h0701_86A0
`define MTIC_RST_SER    32'h0364_0000
`define MTIC_WM_CTRL    32'h0000_001F
`define MTIC_WM_PAIR    32'h0FFF_0FFF
`define MTIC_WM_TNEU    32'h0000_0FFF
`define MTIC_WM_LOOP    32'h070F_FFFF

// Timing
`define MTIC_CLK_HZ     100000000
`define MTIC_TICK_HZ    1500000
`define MTIC_TICK_NUM   (`MTIC_TICK_HZ / 500000)
`define MTIC_TICK_DEN   (`MTIC_CLK_HZ / 500000)
`define MTIC_STALE_MS   120
`define MTIC_STALE_CYC  ((`MTIC_CLK_HZ / 1000) * `MTIC_STALE_MS)
`define MTIC_PW_MIN_US  400
`define MTIC_PW_MAX_US  2600
`define MTIC_PW_MIN_TK  ((`MTIC_PW_MIN_US * (`MTIC_TICK_HZ / 1000) + 999) / 1000)
`define MTIC_PW_MAX_TK  ((`MTIC_PW_MAX_US * (`MTIC_TICK_HZ / 1000)) / 1000)
`define MTIC_FMIN_HZ    10
`define MTIC_FMAX_HZ    150
`define MTIC_PER_MIN_TK ((`MTIC_TICK_HZ + `MTIC_FMAX_HZ - 1) / `MTIC_FMAX_HZ)
`define MTIC_PER_MAX_TK (`MTIC_TICK_HZ / `MTIC_FMIN_HZ)
`define MTIC_RUN_NEED   4
`define MTIC_DISC_EVERY 16
`endif

// File: include/mtic_pkg.sv
package mtic_pkg;
    typedef enum logic [1:0] {MODE_SERIAL, MODE_ANALOG, MODE_PULSE, MODE_SPARE} mtic_mode_t;

    typedef struct packed {
        logic        done;
        logic [9:0]  code;
    } mtic_adc_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        crc_ok;
        logic [11:0] target;
    } mtic_ser_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [11:0] target;
    } mtic_tgt_t;

    typedef struct packed {
        logic        rx_d;
        logic        seen;
        logic [12:0] hi_cnt;
        logic [17:0] per_cnt;
        logic [2:0]  run;
        logic        upd;
        logic [11:0] width;
    } mtic_pw_st_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic [31:0] ctrl;
        logic [3:0]  status;
        logic [3:0]  mask;
        logic [31:0] absw;
        logic [31:0] spanw;
        logic [31:0] neuw;
        logic [31:0] tgtw;
        logic [31:0] tneuw;
        logic [31:0] loopw;
        logic [31:0] serw;
        logic [11:0] cmd_tgt;
        logic [19:0] loop_cnt;
        logic        an_busy;
        logic [7:0]  an_cnt;
        logic [19:0] an_sum;
        logic        adc_start;
        logic [3:0]  disc_cnt;
        logic        disc_now;
        logic        aux_out;
        logic        aux_oe_n;
        logic [11:0] raw_an;
        logic [11:0] raw;
        mtic_tgt_t   tgt;
        logic [15:0] ser_idle;
        logic [23:0] stale_cnt;
        logic [7:0]  phase;
        logic        tick15;
        logic        rx1;
        logic        rx2;
    } mtic_st_t;
endpackage

// File: design/mtic_pulse.sv
`timescale 1ns/10ps
`include "mtic_regs.svh"
module mtic_pulse (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // Tick and synchronised receive level
    input  wire logic        tick,
    input  wire logic        rx,
    // Accepted width
    output logic             upd,
    output logic [11:0]      width
);
    mtic_pkg::mtic_pw_st_t s;
    mtic_pkg::mtic_pw_st_t next_s;

    assign upd   = s.upd;
    assign width = s.width;

    always_comb begin
        next_s     = s;
        next_s.upd = 1'b0;
        if (tick) begin
            next_s.rx_d = rx;
            if (s.per_cnt != 18'h3_FFFF)
                next_s.per_cnt = s.per_cnt + 18'h0_0001;
            if (rx && s.hi_cnt != 13'h1FFF)
                next_s.hi_cnt = s.hi_cnt + 13'h0001;
            // No edge for too long: the repetition rate is below limit
            if (s.per_cnt > 18'(`MTIC_PER_MAX_TK))
                next_s.run = 3'h0;
            if (rx && !s.rx_d) begin
                if (s.seen && (s.per_cnt < 18'(`MTIC_PER_MIN_TK)
                               || s.per_cnt > 18'(`MTIC_PER_MAX_TK)))
                    next_s.run = 3'h0;
                next_s.seen    = 1'b1;
                next_s.per_cnt = 18'h0_0000;
                next_s.hi_cnt  = 13'h0001;
            end
            if (!rx && s.rx_d && s.seen) begin
                if (s.hi_cnt >= 13'(`MTIC_PW_MIN_TK) && s.hi_cnt <= 13'(`MTIC_PW_MAX_TK)) begin
                    if (s.run != 3'(`MTIC_RUN_NEED))
                        next_s.run = s.run + 3'h1;
                    if (s.run >= 3'(`MTIC_RUN_NEED - 1)) begin
                        next_s.upd   = 1'b1;
                        next_s.width = s.hi_cnt[11:0];
                    end
                end else begin
                    next_s.run = 3'h0;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// File: bench/mtic_properties.sv
`timescale 1ns/10ps
module mtic_properties (
    // Clock and reset
    input wire logic                core_clk,
    input wire logic                resetn,
    // APB
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [31:0]         prdata,
    // Pins and outputs
    input wire logic                aux_out,
    input wire logic                aux_oe_n,
    input wire logic                adc_start,
    input wire logic                crc_en,
    input wire logic [15:0]         baud_div,
    input wire mtic_pkg::mtic_tgt_t target
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic wr_done;
    assign wr_done = psel && penable && pwrite && pready;
    apb_answer_a: assert property (psel && penable |-> ##[0:2] pready)
        else $error("pready missing");
    ready_once_a: assert property (pready |=> !pready)
        else $error("pready too long");
    err_data_a: assert property (pslverr |-> pready && !pwrite && prdata == 32'h0000_0000)
        else $error("bad error answer");
    adc_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("adc_start too long");
    tgt_once_a: assert property (target.valid |=> !target.valid [*8])
        else $error("target update too often");
    tgt_hold_a: assert property ($changed(target.target) |-> target.valid)
        else $error("target moved off tick");
    aux_drive_a: assert property (!aux_out |-> !aux_oe_n)
        else $error("aux low while undriven");
    crc_cfg_a: assert property ($changed(crc_en) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("crc_en moved without write");
    baud_cfg_a: assert property ($changed(baud_div) |-> $past(wr_done) || $past(wr_done, 2))
        else $error("baud_div moved without write");
endmodule

bind mtic_top mtic_properties u_props (.*);

// File: bench/mtic_adc_model.sv
`timescale 1ns/10ps
module mtic_adc_model (
    // Clock
    input wire logic                core_clk,
    // Request and answer
    input wire logic                adc_start,
    output mtic_pkg::mtic_adc_rsp_t adc_rsp,
    // Behaviour chosen by the bench
    input wire logic [9:0]          code,
    input wire logic [7:0]          dly
);
    int cnt = 0;
    initial adc_rsp = '0;
    always @(posedge core_clk) begin
        // Junk code outside done
        adc_rsp <= {1'b0, ~adc_rsp.code};
        if (adc_start) begin
            cnt <= int'(dly);
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            adc_rsp <= {1'b1, code};
        end
    end
endmodule

// File: bench/tb_motor_target_input_conditioner.sv
`timescale 1ns/10ps
`include "mtic_regs.svh"
module tb_motor_target_input_conditioner;
    logic                    core_clk, resetn, psel, penable, pwrite, rx_pin, rd_err;
    logic [7:0]              paddr, dly;
    logic [31:0]             pwdata, prdata, rd_val;
    logic                    pready, pslverr, irq, aux_out, aux_oe_n, adc_start, crc_en;
    logic [9:0]              code;
    logic [15:0]             baud_div;
    mtic_pkg::mtic_adc_rsp_t adc_rsp;
    mtic_pkg::mtic_ser_cmd_t ser_cmd;
    mtic_pkg::mtic_tgt_t     target;
    int                      num_errors = 0;
    int                      checks = 0;

    mtic_top #(.STALE_CYC(2000)) DUT (.*);
    mtic_adc_model u_adc (.core_clk(core_clk), .adc_start(adc_start), .adc_rsp(adc_rsp),
        .code(code), .dly(dly));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
        chk("pready", 1, pready);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd_val);
    endtask
    // Bounded wait on loop ticks
    task automatic ticks(input int k);
        int n;
        n = 0;
        repeat (k) do @(posedge core_clk); while (target.valid !== 1'b1 && ++n < 5000);
        if (n >= 5000) chk("tick", 1, 0);
    endtask
    task automatic cmd(input logic ok, input logic [11:0] t);
        ser_cmd <= {1'b1, ok, t};
        @(posedge core_clk);
        ser_cmd.valid <= 1'b0;
        ticks(2);
    endtask
    task automatic an(input logic [9:0] c, input logic [31:0] ctl);
        code <= c;
        apb(1'b1, `MTIC_OFF_CTRL, ctl);
        ticks(3);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk("aux_oe_n", 1, aux_oe_n);
        chk("baud_div", 16'h0364, baud_div);
        rd("abs", `MTIC_OFF_ABS, `MTIC_RST_ABS);
        rd("loop", `MTIC_OFF_LOOP, `MTIC_RST_LOOP);
        rd("ser", `MTIC_OFF_SER, `MTIC_RST_SER);
        rd("unmapped", 8'h30, 32'h0000_0000);
        chk("pslverr", 1, rd_err);
        apb(1'b1, `MTIC_OFF_LOOP, 32'h0200_00C8);
    endtask
    task automatic t_serial();
        cmd(1'b1, 12'h123);
        chk("serial target", 12'h123, target.target);
        apb(1'b1, `MTIC_OFF_CTRL, 32'h0000_0008);
        chk("crc_en", 1, crc_en);
        cmd(1'b0, 12'h456);
        chk("bad crc dropped", 12'h123, target.target);
        cmd(1'b1, 12'h456);
        chk("good crc", 12'h456, target.target);
        apb(1'b1, `MTIC_OFF_SER, 32'h0364_0002);
        ticks(4);
        rd("silence", `MTIC_OFF_STATUS, 32'h0000_0004);
        chk("irq masked", 0, irq);
        apb(1'b1, `MTIC_OFF_MASK, 32'h0000_0004);
        chk("irq", 1, irq);
        apb(1'b1, `MTIC_OFF_SER, 32'h0364_0000);
        apb(1'b1, `MTIC_OFF_STATUS, 32'h0000_000F);
        ticks(4);
        rd("silence off", `MTIC_OFF_STATUS, 32'h0000_0000);
        chk("irq clear", 0, irq);
    endtask
    task automatic t_analog();
        an(10'h3FF, 32'h0000_0001);
        rd("raw", `MTIC_OFF_STATE, {4'h8, 12'hFFC, 4'h0, 12'hFFC});
        an(10'h000, 32'h0000_0001);
        chk("min", 12'h000, target.target);
        an(10'h000, 32'h0000_0005);
        chk("inverted", 12'hFFF, target.target);
        apb(1'b1, `MTIC_OFF_NEU, 32'h0F00_0100);
        an(10'h100, 32'h0000_0001);
        chk("dead zone", 12'h800, target.target);
        apb(1'b1, `MTIC_OFF_ABS, 32'h0FFF_0010);
        an(10'h000, 32'h0000_0001);
        rd("range", `MTIC_OFF_STATUS, 32'h0000_0001);
        apb(1'b1, `MTIC_OFF_ABS, `MTIC_RST_ABS);
        dly <= 8'd100;
        ticks(3);
        apb(1'b1, `MTIC_OFF_STATUS, 32'h0000_000F);
        ticks(2);
        apb(1'b0, `MTIC_OFF_STATUS, 32'h0000_0000);
        chk("overrun", 1, rd_val[3]);
        chk("range cleared", 0, rd_val[0]);
        dly <= 8'd3;
        ticks(2);
    endtask
    task automatic t_disc();
        an(10'h000, 32'h0000_0011);
        chk("aux driven", 0, aux_oe_n);
        apb(1'b1, `MTIC_OFF_STATUS, 32'h0000_000F);
        ticks(17);
        rd("pot present", `MTIC_OFF_STATUS, 32'h0000_0000);
        an(10'h200, 32'h0000_0011);
        ticks(17);
        apb(1'b0, `MTIC_OFF_STATUS, 32'h0000_0000);
        chk("pot lost", 1, rd_val[0]);
    endtask
    task automatic t_stale();
        an(10'h000, 32'h0000_0002);
        apb(1'b1, `MTIC_OFF_STATUS, 32'h0000_000F);
        ticks(12);
        apb(1'b0, `MTIC_OFF_STATUS, 32'h0000_0000);
        chk("stale", 1, rd_val[1]);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        conclude();
    end
    initial begin
        {resetn, psel, penable, pwrite, paddr, pwdata, rx_pin} = '0;
        ser_cmd = '0;
        code = 10'h000;
        dly = 8'd3;
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_serial();
        t_analog();
        t_disc();
        t_stale();
        conclude();
    end
endmodule
